/* active_power_to_frequency_tb.sv */
// Self-checking bench for the power path
`timescale 1ns/1ps
`default_nettype none
module active_power_to_frequency_tb;
  logic                ref_clk = 1'b0;
  logic                rst = 1'b1;
  logic signed  [15:0] curS = 16'h0000;
  logic signed  [15:0] volS = 16'h0000;
  logic                sup = 1'b0;
  logic                hpf = 1'b0;
  logic          [3:0] sel = 4'h0; // Gain msb, lsb, rate msb, lsb
  aptf_pkg::aptf_bus_t b = '0;
  logic         [31:0] rdData;
  logic         [31:0] d;
  logic                outA_n, outB_n, outCf_n;
  logic         [15:0] cfCount;
  int                  num_errors = 0;
  int                  cmp_count = 0;
  initial forever #50 ref_clk = ~ref_clk;
  aptf_top aptf_top_i (.ref_clk(ref_clk), .rst(rst), .currentSample(curS),
    .voltageSample(volS), .analogSupply(sup), .hpfSelectIn(hpf),
    .gainSelectLsb(sel[2]), .gainSelectMsb(sel[3]), .rateSelectLsb(sel[0]),
    .rateSelectMsb(sel[1]), .bus(b), .rdData(rdData), .slowPulseOutA_n(outA_n),
    .slowPulseOutB_n(outB_n), .calibrationPulseOut_n(outCf_n));
  aptf_counter aptf_counter_i (.ref_clk(ref_clk), .rst(rst), .pulseIn_n(outCf_n),
    .count(cfCount));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge ref_clk) b <= '{a, v, 1'b1, 1'b0};
    @(posedge ref_clk) b.wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge ref_clk) b <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge ref_clk) b.rd <= 1'b0;
    #1 v = rdData;
  endtask
  task automatic ticks(input int n);
    repeat (n * (int'(aptf_pkg::SAMPLE_CYC_M1) + 1)) @(posedge ref_clk);
  endtask
  task automatic print_verdict;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Scale clamp, read-only status, unmapped place
  task automatic t_regs;
    rd(4'hC, d);
    chk(d, 32'h0);
    wr(4'h0, 32'h0000_000F);
    rd(4'h0, d);
    chk(d, 32'h0000_000B);
    wr(4'h4, 32'hFFFF_FFFF);
    rd(4'h4, d);
    chk(d, 32'h0);
  endtask
  // Supply must stay good for the whole filter time
  task automatic t_supply;
    @(posedge ref_clk) sup <= 1'b1;
    ticks(270);
    rd(4'h4, d);
    chk(32'(d[0]), 32'h0);
    for (int i = 0; i < 30 && d[0] !== 1'b1; i++) begin
      ticks(1);
      rd(4'h4, d);
    end
    chk(32'(d[0]), 32'h1);
  endtask
  // Full-scale dc power at top gain and rate
  task automatic t_power;
    @(posedge ref_clk) begin
      curS <= 16'h7FFF;
      volS <= 16'h7FFF;
      sel  <= 4'hF;
      // Dc removal on: its slow corner barely trims a short dc run
      hpf  <= 1'b1;
    end
    for (int i = 0; i < 36000 && outCf_n !== 1'b0; i++) @(posedge ref_clk);
    #1 chk(32'(outCf_n), 32'h0);
    ticks(3);
    #1 chk(32'(outCf_n), 32'h1);
    chk(32'(cfCount != 16'h0), 32'h1);
    chk(32'({outA_n, outB_n}), 32'h3);
    rd(4'h8, d);
    chk(d, 32'h0);
  endtask
  // Reset mid-run drops supply state and silences outputs
  task automatic t_reset;
    @(posedge ref_clk) rst <= 1'b1;
    @(posedge ref_clk) rst <= 1'b0;
    rd(4'h4, d);
    chk(d, 32'h0);
    ticks(5);
    #1 chk(32'({outA_n, outB_n, outCf_n}), 32'h7);
  endtask
  initial begin
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    t_regs();
    t_supply();
    t_power();
    t_reset();
    print_verdict();
  end
  // Hang guard
  initial begin
    repeat (160000) @(posedge ref_clk);
    num_errors++;
    print_verdict();
  end
endmodule
`default_nettype wire

/* aptf_counter.sv */
// Meter-side pulse counter
`timescale 1ns/1ps
`default_nettype none
module aptf_counter (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // Pulse in, count out
  input  wire logic        pulseIn_n,
  output logic      [15:0] count
);
  logic last_r;
  // Counting over a long window averages away CF ripple
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      last_r <= 1'b1;
      count  <= 16'h0000;
    end else begin
      last_r <= pulseIn_n;
      if (last_r && !pulseIn_n) count <= count + 16'h0001;
    end
  end
endmodule
`default_nettype wire

/* aptf_pkg.sv */
// Constants and types for the active power to frequency path
package aptf_pkg;

  // Master clock and internal sample rate
  localparam int unsigned CLK_HZ      = 10_000_000;
  localparam int unsigned SAMPLE_HZ   = 27_965;
  localparam logic [8:0]  SAMPLE_CYC_M1 = 9'(CLK_HZ / SAMPLE_HZ - 1);

  // Product low-pass corner, in centi-hertz (8.9 Hz)
  localparam int unsigned LPF_CORNER_CHZ = 890;
  // Shift giving 2^-k close to 2*pi*fc/fs
  localparam int unsigned LPF_SHIFT =
    $clog2((SAMPLE_HZ * 100) / ((6283 * LPF_CORNER_CHZ) / 1000));
  // Dc-removal shift for current and voltage channels, corner well below line frequency
  localparam int unsigned HPF_SHIFT = 12;

  // Supply monitor filter time, in ms, and its length in sample ticks
  localparam int unsigned SUP_FILT_MS = 10;
  localparam logic [8:0]  SUP_FILT_TICKS = 9'(SAMPLE_HZ * SUP_FILT_MS / 1000);

  // Output pulse widths
  localparam int unsigned SLOW_PULSE_MS = 90;
  localparam logic [11:0] SLOW_PULSE_TICKS = 12'(SAMPLE_HZ * SLOW_PULSE_MS / 1000);
  localparam logic [11:0] CF_PULSE_TICKS   = 12'h002;

  // Energy per slow pulse at the slowest rate selection
  localparam logic [43:0] SLOW_BASE = 44'h400_0000_0000;
  // Calibration output runs at most 2^11 = 2048 times the slow rate
  localparam logic [3:0]  CF_SCALE_MAX = 4'hB;
  localparam logic [3:0]  CF_SCALE_RST = 4'h0;

  // Register offsets
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_COUNT  = 4'h8;

  // Register bus request
  typedef struct packed {
    logic [3:0]  addr;
    logic [31:0] wData;
    logic        wr;
    logic        rd;
  } aptf_bus_t;

  // Whole state of the block
  typedef struct packed {
    logic [8:0]         tickCnt;
    logic [8:0]         supCnt;
    logic               supplyGood;
    logic signed [31:0] dcI;
    logic signed [31:0] dcV;
    logic signed [31:0] lpf;
    logic [43:0]        slowAcc;
    logic [43:0]        cfAcc;
    logic [11:0]        slowW;
    logic [11:0]        cfW;
    logic               slowSel;
    logic               outA_n;
    logic               outB_n;
    logic               outCf_n;
    logic [3:0]         cfScale;
    logic [15:0]        pulseCount;
    logic [31:0]        rdData;
  } aptf_state_t;

  localparam aptf_state_t ST_RESET = '{
    outA_n: 1'b1, outB_n: 1'b1, outCf_n: 1'b1,
    cfScale: CF_SCALE_RST, default: '0};

endpackage

/* aptf_top.sv */
// Active power path: filters, multiplier and pulse-rate converter
//
// Overview of operation
// [RULE1] HPF removes current dc when selected
// [RULE2] Phase compensation only while HPF enabled
// [RULE3] Filtered product dc accumulates as power
// [RULE4] First-order product LPF, 8.9 Hz corner
// [RULE5] Integrate LPF output into pulse rate
// [RULE6] Calibration rate up to 2048 times slow
// [RULE7] Slow outputs from much longer accumulation
// [RULE8] Hold reset while supply below 4 V
// [RULE9] Supply decision filtered with hysteresis
// [RULE10] Counter averages calibration pulses over time
// [RULE11] Current gain 1, 2, 8 or 16
// [RULE12] Multiply current and voltage samples directly
// [RULE13] Slow pulses are active low
// [RULE14] Four base rates, binary clock fractions
// [RULE15] Reset clears accumulators, no pulses
`timescale 1ns/1ps
`default_nettype none

module aptf_top (
  // Clock and reset
  input  wire logic               ref_clk,
  input  wire logic               rst,
  // Converter samples and supply comparator
  input  wire logic signed [15:0] currentSample,
  input  wire logic signed [15:0] voltageSample,
  input  wire logic               analogSupply,
  // Mode pins
  input  wire logic               hpfSelectIn,
  input  wire logic               gainSelectLsb,
  input  wire logic               gainSelectMsb,
  input  wire logic               rateSelectLsb,
  input  wire logic               rateSelectMsb,
  // Register port
  input  wire aptf_pkg::aptf_bus_t bus,
  output logic             [31:0] rdData,
  // Pulse outputs
  output logic                    slowPulseOutA_n,
  output logic                    slowPulseOutB_n,
  output logic                    calibrationPulseOut_n
);

  aptf_pkg::aptf_state_t s;
  aptf_pkg::aptf_state_t n;

  logic               tick;
  logic signed [32:0] diffI;
  logic signed [32:0] diffV;
  logic signed [15:0] hpI;
  logic signed [15:0] hpV;
  logic        [2:0]  gainShift;
  logic signed [20:0] gI;
  logic signed [36:0] prod;
  logic signed [31:0] power;
  logic signed [32:0] diffL;
  logic        [43:0] pos;
  logic        [43:0] slowThr;
  logic        [43:0] cfThr;
  logic        [43:0] slowSum;
  logic        [43:0] cfSum;

  // Datapath terms, all from current state and pins
  always_comb begin
    tick  = (s.tickCnt == aptf_pkg::SAMPLE_CYC_M1);
    diffI = $signed({currentSample[15], currentSample, 16'h0000})
            - $signed({s.dcI[31], s.dcI});
    diffV = $signed({voltageSample[15], voltageSample, 16'h0000})
            - $signed({s.dcV[31], s.dcV});
    // Dc estimate subtracted only while the filter is selected
    hpI = hpfSelectIn ? diffI[31:16] : currentSample; // [RULE1]
    // Voltage sees the same filter, so both channels share its phase
    hpV = hpfSelectIn ? diffV[31:16] : voltageSample; // [RULE2]
    case ({gainSelectMsb, gainSelectLsb}) // [RULE11]
      2'b00:   gainShift = 3'h0;
      2'b01:   gainShift = 3'h1;
      2'b10:   gainShift = 3'h3;
      2'b11:   gainShift = 3'h4;
      default: gainShift = 3'h0;
    endcase
    gI    = {{5{hpI[15]}}, hpI} <<< gainShift;
    prod  = gI * hpV; // [RULE12]
    power = prod[36:5];
    diffL = $signed({power[31], power}) - $signed({s.lpf[31], s.lpf});
    // Only positive filtered power is counted as energy
    pos = s.lpf[31] ? 44'h000_0000_0000 : {12'h000, s.lpf}; // [RULE3]
    // Higher rate select halves the energy per pulse
    slowThr = aptf_pkg::SLOW_BASE >> {rateSelectMsb, rateSelectLsb}; // [RULE14]
    cfThr   = slowThr >> s.cfScale; // [RULE6]
    slowSum = s.slowAcc + pos;
    cfSum   = s.cfAcc + pos;
  end

  // Next state
  always_comb begin
    n = s;
    n.tickCnt = tick ? 9'h000 : 9'(s.tickCnt + 9'h001);

    // Read data stand for one cycle only
    n.rdData = 32'h0000_0000;
    if (bus.rd) begin
      case (bus.addr)
        aptf_pkg::REG_CTRL:   n.rdData = {28'h000_0000, s.cfScale};
        aptf_pkg::REG_STATUS: n.rdData = {30'h0000_0000, s.slowSel, s.supplyGood};
        aptf_pkg::REG_COUNT:  n.rdData = {16'h0000, s.pulseCount};
        default:              n.rdData = 32'h0000_0000;
      endcase
    end
    if (bus.wr && bus.addr == aptf_pkg::REG_CTRL) begin
      // Out-of-range scale values clamp to the 2048x setting
      n.cfScale = (bus.wData[3:0] > aptf_pkg::CF_SCALE_MAX)
                  ? aptf_pkg::CF_SCALE_MAX : bus.wData[3:0];
    end

    // Supply monitor: integrating counter, switch only at its ends
    if (tick) begin
      if (analogSupply && s.supCnt < aptf_pkg::SUP_FILT_TICKS) begin
        n.supCnt = 9'(s.supCnt + 9'h001); // [RULE9]
      end else if (!analogSupply && s.supCnt != 9'h000) begin
        n.supCnt = 9'(s.supCnt - 9'h001); // [RULE9]
      end
      if (n.supCnt == aptf_pkg::SUP_FILT_TICKS) begin
        n.supplyGood = 1'b1; // [RULE8]
      end else if (n.supCnt == 9'h000) begin
        n.supplyGood = 1'b0; // [RULE8]
      end
    end

    if (!s.supplyGood) begin
      // Logic held in reset: nothing accumulates, no pulse leaves
      n.dcI     = '0; // [RULE8]
      n.dcV     = '0;
      n.lpf     = '0;
      n.slowAcc = '0; // [RULE15]
      n.cfAcc   = '0; // [RULE15]
      n.slowW   = '0;
      n.cfW     = '0;
      n.slowSel = 1'b0;
    end else if (tick) begin
      // Dc trackers; cleared while bypassed so re-enable starts clean
      if (hpfSelectIn) begin
        n.dcI = s.dcI + 32'(diffI >>> aptf_pkg::HPF_SHIFT); // [RULE1]
        n.dcV = s.dcV + 32'(diffV >>> aptf_pkg::HPF_SHIFT); // [RULE2]
      end else begin
        n.dcI = '0; // [RULE2]
        n.dcV = '0;
      end
      // One-pole low-pass on the instantaneous power
      n.lpf = s.lpf + 32'(diffL >>> aptf_pkg::LPF_SHIFT); // [RULE4]

      // Slow converter: long integration averages out line ripple
      if (slowSum >= slowThr) begin
        n.slowAcc    = slowSum - slowThr; // [RULE7]
        n.slowW      = aptf_pkg::SLOW_PULSE_TICKS;
        n.slowSel    = ~s.slowSel;
        n.pulseCount = 16'(s.pulseCount + 16'h0001);
      end else begin
        n.slowAcc = slowSum; // [RULE5]
        if (s.slowW != 12'h000) begin
          n.slowW = 12'(s.slowW - 12'h001);
        end
      end

      // Calibration converter: short integration, ripple passes
      if (cfSum >= cfThr) begin
        n.cfAcc = cfSum - cfThr; // [RULE6]
        n.cfW   = aptf_pkg::CF_PULSE_TICKS;
      end else begin
        n.cfAcc = cfSum; // [RULE5]
        if (s.cfW != 12'h000) begin
          n.cfW = 12'(s.cfW - 12'h001);
        end
      end
    end

    // Slow pulses alternate between the two pins, low while active
    n.outA_n  = !(n.slowW != 12'h000 && !n.slowSel); // [RULE13]
    n.outB_n  = !(n.slowW != 12'h000 && n.slowSel);  // [RULE13]
    n.outCf_n = !(n.cfW != 12'h000); // [RULE15]
  end

  // State register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s <= aptf_pkg::ST_RESET;
    end else begin
      s <= n;
    end
  end

  // Outputs straight from state flops
  assign rdData                = s.rdData;
  assign slowPulseOutA_n       = s.outA_n;
  assign slowPulseOutB_n       = s.outB_n;
  assign calibrationPulseOut_n = s.outCf_n;

endmodule

`default_nettype wire

/* aptf_top_sva.sv */
// Port checker for the power path
`timescale 1ns/1ps
`default_nettype none
module aptf_chk (
  // Clock and reset
  input wire logic                ref_clk,
  input wire logic                rst,
  // Register port
  input wire aptf_pkg::aptf_bus_t bus,
  input wire logic         [31:0] rdData,
  // Pulse outputs
  input wire logic                slowPulseOutA_n,
  input wire logic                slowPulseOutB_n,
  input wire logic                calibrationPulseOut_n
);
  logic [11:0] lowCnt_r;
  // Length of the CF low phase; a refire may stretch it
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst || calibrationPulseOut_n) lowCnt_r <= 12'h000;
    else lowCnt_r <= lowCnt_r + 12'h001;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_rd(logic [3:0] a); bus.rd && bus.addr == a; endsequence
  sequence s_low(logic s); (!s) [*8]; endsequence
  property p_rd_idle; rdData != 32'h0 |-> $past(bus.rd); endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read");
  property p_unmap; bus.rd && !(bus.addr inside {4'h0, 4'h4, 4'h8}) |=> rdData == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_status; s_rd(4'h4) |=> rdData[31:2] == 30'h0; endproperty
  a_status: assert property (p_status) else $error("status high bits set");
  property p_ctrl; s_rd(4'h0) |=> rdData <= 32'h0000_000B; endproperty
  a_ctrl: assert property (p_ctrl) else $error("fast scale above limit");
  property p_cf_low; $fell(calibrationPulseOut_n) |-> s_low(calibrationPulseOut_n); endproperty
  a_cf_low: assert property (p_cf_low) else $error("fast pulse too short");
  property p_cf_width; $rose(calibrationPulseOut_n) |-> $past(lowCnt_r) >= 12'h2BC; endproperty
  a_cf_width: assert property (p_cf_width) else $error("fast pulse width");
  property p_slow_low; $fell(slowPulseOutA_n) |-> s_low(slowPulseOutA_n); endproperty
  a_slow_low: assert property (p_slow_low) else $error("slow pulse too short");
  property p_quiet; $fell(rst) |-> slowPulseOutA_n && slowPulseOutB_n && calibrationPulseOut_n; endproperty
  a_quiet: assert property (p_quiet) else $error("pulse out of reset");
endmodule
bind aptf_top aptf_chk aptf_chk_i (.ref_clk(ref_clk), .rst(rst), .bus(bus), .rdData(rdData),
  .slowPulseOutA_n(slowPulseOutA_n), .slowPulseOutB_n(slowPulseOutB_n),
  .calibrationPulseOut_n(calibrationPulseOut_n));
`default_nettype wire
